// ---- rtl/asidr_recovery.sv ----
module asidr_recovery (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // delay-line taps
    input wire logic [asidr_pkg::TAPS-1:0] tap_true,
    input wire logic [asidr_pkg::TAPS-1:0] tap_inv,
    // framing setup
    input wire logic sync_mode,
    input wire logic rs_packets,
    // recovered words
    output logic [asidr_pkg::WORD_W-1:0] word_out,
    output logic word_valid,
    output logic aligned,
    output logic [2:0] sample_tap,
    // decoded stream
    output logic [asidr_pkg::BYTE_W-1:0] data_out,
    output logic data_valid,
    output logic data_sop,
    output logic frame_locked,
    output logic code_err
);
    import asidr_pkg::*;

    function automatic logic is_comma(input logic [WORD_W-1:0] w);
        is_comma = (w[9:3] == COMMA_NEG) || (w[9:3] == COMMA_POS);
    endfunction

    logic [TAPS-1:0] cap_true;
    logic [TAPS-1:0] cap_inv;
    logic [TAPS-1:0] true_d;
    logic [TAPS-1:0] inv_retime;
    logic [NSAMP-1:0] samp;
    logic [NSAMP-2:0] edges;
    logic [TAPS-1:0] pe;
    logic edge_before;
    logic edge_after;
    logic [2:0] ptr;
    asidr_move_t next_move;
    asidr_move_t sp_state;
    logic [1:0] nbits;
    logic [2:0] bits;
    logic [SH_W-1:0] sh;
    logic [SH_W-1:0] next_sh;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [3:0] total;
    logic [3:0] off;
    logic emit;
    asidr_align_t al_state;
    asidr_align_t next_al;
    logic [BYTE_W-1:0] dec_byte;
    logic dec_k;
    logic dec_valid;
    asidr_frame_t fr_state;
    asidr_frame_t next_fr;
    logic [2:0] gap;
    logic [2:0] next_gap;
    logic [7:0] pos;
    logic [7:0] next_pos;
    logic [7:0] plen;
    logic pass;
    logic is_sync;

    // both lines see the same pin; true line on the rising edge
    always_ff @(posedge clk)
    begin
        cap_true <= tap_true;
        true_d <= cap_true;
        inv_retime <= cap_inv;
    end

    // inverse line: same clock net, falling edge, half a period later
    always_ff @(negedge clk)
    begin
        cap_inv <= tap_inv;
    end

    // true line first in time, inverse line second
    assign samp = {inv_retime, true_d};
    assign edges = samp[NSAMP-1:1] ^ samp[NSAMP-2:0];

    // fold both halves onto one set of tap phases
    always_comb
    begin
        pe = edges[TAPS-1:0];
        pe[TAPS-2:0] = edges[TAPS-2:0] | edges[NSAMP-2:TAPS];
        // tap 0 looks back across the half boundary to the last tap
        edge_before = pe[ptr - 3'h1];
        edge_after = pe[ptr];
    end

    // edges on both sides mean a narrow eye: holding beats chasing jitter
    always_comb
    begin
        if (edge_before && !edge_after)
            next_move = SP_LATER;
        else if (edge_after && !edge_before)
            next_move = SP_EARLIER;
        else
            next_move = SP_HOLD;
    end

    // bits taken this cycle, earliest in bits[2]
    always_comb
    begin
        nbits = NB_TWO;
        bits = {samp[{1'b0, ptr}], samp[{1'b1, ptr}], 1'b0};
        // fast line: the last inverse tap already holds a fresh bit
        if (next_move == SP_EARLIER && ptr == FIRST_TAP)
        begin
            nbits = NB_THREE;
            bits = {samp[{1'b0, FIRST_TAP}], samp[{1'b1, FIRST_TAP}], samp[{1'b1, LAST_TAP}]};
        end
        // slow line: the inverse tap would repeat next cycle's first bit
        else if (next_move == SP_LATER && ptr == LAST_TAP)
        begin
            nbits = NB_ONE;
            bits = {samp[{1'b0, LAST_TAP}], 2'b00};
        end
    end

    // sample-point state machine, wraps through the line ends
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ptr <= MID_TAP;
            sp_state <= SP_HOLD;
        end
        else
        begin
            sp_state <= next_move;
            case (next_move)
                SP_LATER: ptr <= ptr + 3'h1;
                SP_EARLIER: ptr <= ptr - 3'h1;
                SP_HOLD: ptr <= ptr;
                default: ptr <= MID_TAP;
            endcase
        end
    end

    assign sample_tap = ptr;

    // deserializer shift, newest bit at the bottom
    always_comb
    begin
        case (nbits)
            NB_ONE: next_sh = {sh[SH_W-2:0], bits[2]};
            NB_THREE: next_sh = {sh[SH_W-4:0], bits};
            default: next_sh = {sh[SH_W-3:0], bits[2:1]};
        endcase
    end

    // word boundary: hunt for a comma, then count ten bits per word
    always_comb
    begin
        total = cnt + {2'b00, nbits};
        next_al = al_state;
        next_cnt = total;
        off = '0;
        emit = 1'b0;
        case (al_state)
            AL_HUNT:
            begin
                next_cnt = '0;
                for (int o = 0; o < 3; o++)
                begin
                    if (o < int'(nbits) && is_comma(next_sh[o +: WORD_W]))
                    begin
                        emit = 1'b1;
                        off = 4'(o);
                        next_cnt = 4'(o);
                        next_al = AL_LOCKED;
                    end
                end
            end
            AL_LOCKED:
            begin
                if (total >= WORD_BITS)
                begin
                    emit = 1'b1;
                    off = total - WORD_BITS;
                    next_cnt = total - WORD_BITS;
                end
            end
            default: next_al = AL_HUNT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sh <= '0;
            cnt <= '0;
            al_state <= AL_HUNT;
            word_out <= '0;
            word_valid <= 1'b0;
        end
        else
        begin
            sh <= next_sh;
            cnt <= next_cnt;
            al_state <= next_al;
            word_valid <= emit;
            if (emit)
                word_out <= next_sh[off +: WORD_W];
        end
    end

    assign aligned = (al_state == AL_LOCKED);

    asidr_decoder u_dec (
        .clk(clk),
        .rst_n(rst_n),
        .sym(word_out),
        .sym_valid(word_valid),
        .dec_byte(dec_byte),
        .dec_k(dec_k),
        .dec_err(code_err),
        .dec_valid(dec_valid)
    );

    // sync stage: commas are stuffing and get deleted here
    always_comb
    begin
        plen = rs_packets ? PKT_LEN_RS : PKT_LEN;
        is_sync = (dec_byte == MPEG_SYNC);
        next_fr = fr_state;
        next_gap = gap;
        next_pos = pos;
        pass = 1'b0;
        if (dec_valid && !dec_k)
        begin
            case (fr_state)
                FR_SEARCH:
                begin
                    if (is_sync && sync_mode)
                    begin
                        next_fr = FR_CONFIRM;
                        next_gap = 3'h1;
                    end
                    else if (is_sync)
                    begin
                        next_fr = FR_LOCKED;
                        next_pos = 8'h1;
                        pass = 1'b1;
                    end
                end
                FR_CONFIRM:
                begin
                    if (is_sync && gap < SYNC_WINDOW)
                    begin
                        next_fr = FR_LOCKED;
                        next_pos = 8'h1;
                        pass = 1'b1;
                    end
                    else if (gap + 3'h1 >= SYNC_WINDOW)
                        next_fr = FR_SEARCH;
                    else
                        next_gap = gap + 3'h1;
                end
                FR_LOCKED:
                begin
                    pass = 1'b1;
                    next_pos = (pos == plen - 8'h1) ? 8'h0 : pos + 8'h1;
                end
                default: next_fr = FR_SEARCH;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fr_state <= FR_SEARCH;
            gap <= '0;
            pos <= '0;
            data_out <= '0;
            data_valid <= 1'b0;
            data_sop <= 1'b0;
        end
        else
        begin
            fr_state <= next_fr;
            gap <= next_gap;
            pos <= next_pos;
            data_valid <= pass;
            data_sop <= pass && (next_pos == 8'h1);
            if (pass)
                data_out <= dec_byte;
        end
    end

    assign frame_locked = (fr_state == FR_LOCKED);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_sampler_budget: assert property (SAMPLES_PER_BIT >= MIN_VALID_SAMPLES && BIT_PS > TAP_DELAY_PS)
        else $error("tap delay too coarse for the line rate");
    chk_reset_mid_tap: assert property (disable iff (1'b0) !rst_n |=> ptr == MID_TAP && !aligned && !word_valid)
        else $error("reset did not restore the middle tap");
    chk_word_aligned: assert property (word_valid |-> aligned)
        else $error("word emitted before alignment");
    chk_word_strobe: assert property (word_valid |=> !word_valid)
        else $error("word strobe longer than one cycle");
    chk_ptr_later: assert property (next_move == SP_LATER |=> ptr == $past(ptr) + 3'h1 && sp_state == SP_LATER)
        else $error("sample point did not move away from edge");
    chk_three_bits: assert property (nbits == NB_THREE |-> ptr == FIRST_TAP ##1 ptr == LAST_TAP)
        else $error("three bits taken without wrap");
    chk_one_bit: assert property (nbits == NB_ONE |-> ptr == LAST_TAP ##1 ptr == FIRST_TAP)
        else $error("one bit taken without wrap");
    chk_edge_hold: assert property (edge_before && edge_after |=> $stable(ptr))
        else $error("sample point moved inside a closed eye");
    chk_decode_delay: assert property (word_valid |=> dec_valid)
        else $error("decoder missed a word");
    chk_mode0_lock: assert property (!sync_mode && fr_state == FR_SEARCH && dec_valid && !dec_k && is_sync
        |=> frame_locked && data_valid && data_out == MPEG_SYNC)
        else $error("first sync did not lock");
    chk_comma_dropped: assert property (dec_valid && dec_k |=> !data_valid)
        else $error("comma passed to the stream");
endmodule

// ---- inc/asidr_pkg.sv ----
package asidr_pkg;
    // line and sampler timing
    localparam int LINE_RATE_MBPS = 270;
    localparam int TAP_DELAY_PS = 700;
    localparam int BIT_PS = 1000000 / LINE_RATE_MBPS;
    localparam int SAMPLES_PER_BIT = BIT_PS / TAP_DELAY_PS;
    localparam int MIN_VALID_SAMPLES = 2;
    localparam int JITTER_PP_MUI = 500;
    localparam int RX_CLOCK_MHZ = 135;
    // sampler geometry
    localparam int TAPS = 8;
    localparam int NSAMP = 2 * TAPS;
    localparam logic [2:0] FIRST_TAP = 3'h0;
    localparam logic [2:0] MID_TAP = 3'h4;
    localparam logic [2:0] LAST_TAP = 3'h7;
    localparam logic [3:0] TRIPLE_MID = 4'hb;
    // bits taken per cycle
    localparam logic [1:0] NB_ONE = 2'h1;
    localparam logic [1:0] NB_TWO = 2'h2;
    localparam logic [1:0] NB_THREE = 2'h3;
    // word layout
    localparam int WORD_W = 10;
    localparam int BYTE_W = 8;
    localparam int SH_W = 16;
    localparam logic [3:0] WORD_BITS = 4'ha;
    localparam logic [6:0] COMMA_NEG = 7'h1f;
    localparam logic [6:0] COMMA_POS = 7'h60;
    localparam logic [5:0] K28_NEG = 6'h0f;
    localparam logic [5:0] K28_POS = 6'h30;
    localparam logic [4:0] K28_VAL = 5'h1c;
    // transport framing
    localparam logic [7:0] MPEG_SYNC = 8'h47;
    localparam logic [7:0] PKT_LEN = 8'hbc;
    localparam logic [7:0] PKT_LEN_RS = 8'hcc;
    localparam logic [2:0] SYNC_WINDOW = 3'h5;
    // state encodings
    typedef enum logic [2:0] {SP_HOLD = 3'b001, SP_LATER = 3'b010, SP_EARLIER = 3'b100} asidr_move_t;
    typedef enum logic [1:0] {AL_HUNT = 2'b01, AL_LOCKED = 2'b10} asidr_align_t;
    typedef enum logic [2:0] {FR_SEARCH = 3'b001, FR_CONFIRM = 3'b010, FR_LOCKED = 3'b100} asidr_frame_t;
endpackage

// ---- rtl/asidr_decoder.sv ----
module asidr_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // framed symbol in
    input wire logic [asidr_pkg::WORD_W-1:0] sym,
    input wire logic sym_valid,
    // decoded byte out
    output logic [asidr_pkg::BYTE_W-1:0] dec_byte,
    output logic dec_k,
    output logic dec_err,
    output logic dec_valid
);
    import asidr_pkg::*;

    // abcdei to EDCBA, msb flags an illegal code
    function automatic logic [5:0] dec6(input logic [5:0] c);
        case (c)
            6'h27, 6'h18: dec6 = 6'h00;
            6'h1d, 6'h22: dec6 = 6'h01;
            6'h2d, 6'h12: dec6 = 6'h02;
            6'h31: dec6 = 6'h03;
            6'h35, 6'h0a: dec6 = 6'h04;
            6'h29: dec6 = 6'h05;
            6'h19: dec6 = 6'h06;
            6'h38, 6'h07: dec6 = 6'h07;
            6'h39, 6'h06: dec6 = 6'h08;
            6'h25: dec6 = 6'h09;
            6'h15: dec6 = 6'h0a;
            6'h34: dec6 = 6'h0b;
            6'h0d: dec6 = 6'h0c;
            6'h2c: dec6 = 6'h0d;
            6'h1c: dec6 = 6'h0e;
            6'h17, 6'h28: dec6 = 6'h0f;
            6'h1b, 6'h24: dec6 = 6'h10;
            6'h23: dec6 = 6'h11;
            6'h13: dec6 = 6'h12;
            6'h32: dec6 = 6'h13;
            6'h0b: dec6 = 6'h14;
            6'h2a: dec6 = 6'h15;
            6'h1a: dec6 = 6'h16;
            6'h3a, 6'h05: dec6 = 6'h17;
            6'h33, 6'h0c: dec6 = 6'h18;
            6'h26: dec6 = 6'h19;
            6'h16: dec6 = 6'h1a;
            6'h36, 6'h09: dec6 = 6'h1b;
            6'h0e, 6'h0f, 6'h30: dec6 = 6'h1c;
            6'h2e, 6'h11: dec6 = 6'h1d;
            6'h1e, 6'h21: dec6 = 6'h1e;
            6'h2b, 6'h14: dec6 = 6'h1f;
            default: dec6 = 6'h20;
        endcase
    endfunction

    // fghj to HGF, msb flags an illegal code
    function automatic logic [3:0] dec4(input logic [3:0] c);
        case (c)
            4'hb, 4'h4: dec4 = 4'h0;
            4'h9: dec4 = 4'h1;
            4'h5: dec4 = 4'h2;
            4'hc, 4'h3: dec4 = 4'h3;
            4'hd, 4'h2: dec4 = 4'h4;
            4'ha: dec4 = 4'h5;
            4'h6: dec4 = 4'h6;
            4'he, 4'h1, 4'h7, 4'h8: dec4 = 4'h7;
            default: dec4 = 4'h8;
        endcase
    endfunction

    logic [5:0] lo;
    logic [3:0] hi;
    logic is_k;

    // control symbols carry the minor block inverted on the positive side
    always_comb
    begin
        is_k = (sym[9:4] == K28_NEG) || (sym[9:4] == K28_POS);
        lo = dec6(sym[9:4]);
        hi = dec4((sym[9:4] == K28_POS) ? ~sym[3:0] : sym[3:0]);
    end

    // running disparity is not tracked; only illegal codes are flagged
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dec_byte <= '0;
            dec_k <= 1'b0;
            dec_err <= 1'b0;
            dec_valid <= 1'b0;
        end
        else
        begin
            dec_valid <= sym_valid;
            if (sym_valid)
            begin
                dec_byte <= {hi[2:0], lo[4:0]};
                dec_k <= is_k;
                dec_err <= lo[5] | hi[3];
            end
        end
    end
endmodule

// ---- verification/asidr_tx_model.sv ----
module asidr_tx_model (
    // clock
    input wire logic clk,
    // delay-line taps
    output logic [7:0] tap_true,
    output logic [7:0] tap_inv
);
    timeunit 1ns;
    timeprecision 1ps;
    // negative-disparity column only; the receiver does not track disparity
    localparam logic [5:0] C6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
        6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] C4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
    // bit length in sixteenths of a tap; 128 is nominal, others model rate offset
    int bl = 128;
    int off = 0;
    int h = 0;
    logic [9:0] symq[$];
    logic bitq[$];

    task automatic push_byte(input logic [7:0] b);
        symq.push_back({C6[b[4:0]], C4[b[7:5]]});
    endtask

    task automatic set_link(input int b, input int o);
        bl = b;
        off = o;
        h = 0;
        bitq.delete();
        symq.delete();
    endtask

    task automatic make(output logic [7:0] t);
        longint idx;
        logic [9:0] s;
        for (int k = 0; k < 8; k++)
        begin
            idx = (longint'(8 * h + k) * 16 + off) / bl;
            // idle line carries commas so the receiver can always find the boundary
            while (idx >= bitq.size())
            begin
                s = (symq.size() > 0) ? symq.pop_front() : 10'h0fa;
                for (int i = 9; i >= 0; i--)
                    bitq.push_back(s[i]);
            end
            t[k] = bitq[idx];
        end
        h++;
    endtask

    always @(negedge clk)
    begin
        #2;
        make(tap_true);
    end

    always @(posedge clk)
    begin
        #2;
        make(tap_inv);
    end
endmodule

// ---- verification/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import asidr_pkg::*;
    logic clk;
    logic rst_n;
    logic sync_mode;
    logic rs_packets;
    logic [7:0] tap_true;
    logic [7:0] tap_inv;
    logic [9:0] word_out;
    logic word_valid;
    logic aligned;
    logic [2:0] sample_tap;
    logic [7:0] data_out;
    logic data_valid;
    logic data_sop;
    logic frame_locked;
    logic code_err;
    int bad_count = 0;
    int total_checks = 0;
    logic [8:0] rxq[$];
    logic [8:0] exq[$];

    asidr_tx_model i_tx (.clk(clk), .tap_true(tap_true), .tap_inv(tap_inv));
    asidr_recovery i_dut (.clk(clk), .rst_n(rst_n), .tap_true(tap_true), .tap_inv(tap_inv),
        .sync_mode(sync_mode), .rs_packets(rs_packets), .word_out(word_out), .word_valid(word_valid),
        .aligned(aligned), .sample_tap(sample_tap), .data_out(data_out), .data_valid(data_valid),
        .data_sop(data_sop), .frame_locked(frame_locked), .code_err(code_err));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // sampled mid-cycle, where the strobes have settled
    always @(negedge clk)
    begin
        if (data_valid === 1'b1)
            rxq.push_back({data_sop, data_out});
        if (word_valid === 1'b1)
            chk_flag(aligned, 1'b1);
    end

    function automatic logic [7:0] fill_byte(input int j);
        // only balanced 3b/4b groups, so no false comma and never the sync value
        logic [2:0] hgf [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
        return {hgf[j % 4], 5'(j)};
    endfunction

    task automatic put(input logic [7:0] b, input logic sop, input logic keep);
        i_tx.push_byte(b);
        if (keep)
            exq.push_back({sop, b});
    endtask

    task automatic do_reset(input logic mode, input logic rs, input int b, input int o);
        rst_n = 1'b0;
        sync_mode = mode;
        rs_packets = rs;
        i_tx.set_link(b, o);
        repeat (3) @(posedge clk);
        #1;
        chk_flag(word_valid, 1'b0);
        chk_flag(aligned, 1'b0);
        chk_flag(data_valid, 1'b0);
        chk_flag(frame_locked, 1'b0);
        chk_val(10'(sample_tap), 10'(MID_TAP));
        rst_n = 1'b1;
        repeat (60) @(posedge clk);
        #1;
        chk_flag(aligned, 1'b1);
        rxq.delete();
        exq.delete();
    endtask

    task automatic wait_word(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (word_valid !== 1'b1 && n < 50);
    endtask

    task automatic expect_stream(input int n);
        int k = 0;
        while (rxq.size() < exq.size() && k < n)
        begin
            @(posedge clk);
            k++;
        end
        repeat (40) @(posedge clk);
        #1;
        chk_val(10'(rxq.size()), 10'(exq.size()));
        for (int i = 0; i < exq.size() && i < rxq.size(); i++)
            chk_val(10'(rxq[i]), 10'(exq[i]));
    endtask

    task automatic t_words;
        int n;
        do_reset(1'b0, 1'b0, 128, 0);
        wait_word(n);
        chk_val(word_out, {K28_NEG, 4'ha});
        @(posedge clk);
        #1;
        chk_flag(word_valid, 1'b0);
        wait_word(n);
        chk_val(10'(n), 10'(WORD_W / 2 - 1));
    endtask

    task automatic t_packet(input logic rs, input int len, input int b);
        do_reset(1'b0, rs, b, 0);
        // bytes before the first sync are dropped while searching
        for (int j = 0; j < 3; j++)
            put(fill_byte(j), 1'b0, 1'b0);
        put(MPEG_SYNC, 1'b1, 1'b1);
        for (int j = 1; j < len; j++)
            put(fill_byte(j), 1'b0, 1'b1);
        put(MPEG_SYNC, 1'b1, 1'b1);
        put(fill_byte(9), 1'b0, 1'b1);
        expect_stream(len * 8 + 300);
        chk_flag(frame_locked, 1'b1);
    endtask

    task automatic t_confirm;
        do_reset(1'b1, 1'b0, 128, 0);
        put(MPEG_SYNC, 1'b0, 1'b0);
        for (int j = 1; j < 6; j++)
            put(fill_byte(j), 1'b0, 1'b0);
        put(MPEG_SYNC, 1'b0, 1'b0);
        put(fill_byte(1), 1'b0, 1'b0);
        put(fill_byte(2), 1'b0, 1'b0);
        put(MPEG_SYNC, 1'b1, 1'b1);
        put(fill_byte(3), 1'b0, 1'b1);
        put(fill_byte(4), 1'b0, 1'b1);
        expect_stream(300);
    endtask

    task automatic t_code_err;
        int k = 0;
        do_reset(1'b0, 1'b0, 128, 0);
        put(MPEG_SYNC, 1'b1, 1'b1);
        i_tx.symq.push_back(10'h00f);
        put(fill_byte(5), 1'b0, 1'b1);
        while (code_err !== 1'b1 && k < 100)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        chk_flag(code_err, 1'b1);
        repeat (40) @(posedge clk);
        #1;
        chk_flag(code_err, 1'b0);
        chk_val(10'(rxq[$]), 10'({1'b0, fill_byte(5)}));
    endtask

    task automatic t_phase(input int o, input logic [2:0] tap);
        do_reset(1'b0, 1'b0, 128, o);
        chk_val(10'(sample_tap), 10'(tap));
        put(MPEG_SYNC, 1'b1, 1'b1);
        for (int j = 0; j < 8; j++)
            put(fill_byte(j), 1'b0, 1'b1);
        expect_stream(200);
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    initial
    begin
        rst_n = 1'b0;
        sync_mode = 1'b0;
        rs_packets = 1'b0;
        t_words();
        t_packet(1'b0, int'(PKT_LEN), 128);
        t_packet(1'b1, int'(PKT_LEN_RS), 128);
        // rate offsets force the occasional one- and three-bit cycles
        t_packet(1'b0, int'(PKT_LEN), 126);
        t_packet(1'b0, int'(PKT_LEN), 130);
        t_confirm();
        t_code_err();
        t_phase(64, 3'h5);
        t_phase(48, 3'h3);
        finish_test();
    end
endmodule
